// File: design/twsm_master.sv
// Register-driven two-wire serial master with two clock lines and shared data
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "twsm_regs.svh"
module twsm_master
    import twsm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] scl_o,
    output logic [1:0] scl_oe,
    input wire logic [1:0] scl_i,
    output logic shared_serial_data_pin_o,
    output logic shared_serial_data_pin_oe,
    input wire logic shared_serial_data_pin_i
);
    logic [15:0] ctrl_reg, ctrl_next;
    logic [7:0] raddr_reg, raddr_next;
    logic [1:0] port_reg, port_next;
    logic dir_reg, dir_next;
    logic ready_reg, ready_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [31:0] rd_reg, rd_next;
    logic ack_reg, ack_next;
    logic go_reg, go_next;
    logic nack_reg, nack_next;
    twsm_state_t st_reg, st_next;
    logic [1:0] ph_reg, ph_next;
    logic [3:0] bit_reg, bit_next;
    logic [1:0] byte_reg, byte_next;
    logic [7:0] sh_reg, sh_next;
    logic scl_reg, scl_next;
    logic sda_reg, sda_next;
    logic [1:0] sda_sync_reg;
    logic [1:0] scl_sync0_reg;
    logic [1:0] scl_sync1_reg;
    logic [1:0] scl_oe_reg, scl_oe_next;
    logic sda_oe_reg, sda_oe_next;
    logic rx_bit;
    twsm_tick_if tk ();
    twsm_divider u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .tk(tk)
    );
    assign tk.freq = ctrl_reg[5:4];
    assign tk.run = (st_reg != TWSM_IDLE) && (st_reg != TWSM_DONE);
    // Stretch sense is synchronised only for visibility; the master never waits on it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sda_sync_reg <= 2'b11;
            scl_sync0_reg <= 2'b11;
            scl_sync1_reg <= 2'b11;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], shared_serial_data_pin_i};
            scl_sync0_reg <= scl_i;
            scl_sync1_reg <= scl_sync0_reg;
        end
    end
    assign rx_bit = sda_sync_reg[1];
    function automatic logic [15:0] cmd_word(input logic rdy, input logic [1:0] p,
                                             input logic d, input logic [7:0] a);
        cmd_word = {rdy, 3'b000, p, 1'b0, d, a};
    endfunction : cmd_word
    // Bus slave: one wait cycle per access, so waitrequest is low on the second cycle
    always_comb begin
        ctrl_next = ctrl_reg;
        raddr_next = raddr_reg;
        port_next = port_reg;
        dir_next = dir_reg;
        wdata_next = wdata_reg;
        go_next = 1'b0;
        ack_next = 1'b0;
        rd_next = rd_reg;
        if ((avs_read || avs_write) && !ack_reg) begin
            ack_next = 1'b1;
            rd_next = 32'h0000_0000;
            if (avs_read) begin
                case (avs_address)
                    `TWSM_OFF_CTRL: rd_next = {16'h0000, ctrl_reg};
                    `TWSM_OFF_CMD: rd_next = {16'h0000, cmd_word(ready_reg, port_reg,
                                                                 dir_reg, raddr_reg)};
                    `TWSM_OFF_DATA: rd_next = {16'h0000, rdata_reg, wdata_reg};
                    default: rd_next = 32'h0000_0000;
                endcase
            end
        end
        // Writes land only at the edge that completes the access, with waitrequest low
        if (avs_write && ack_reg) begin
            case (avs_address)
                `TWSM_OFF_CTRL: ctrl_next = avs_writedata[15:0];
                `TWSM_OFF_CMD: begin
                    // Dropped whole while busy, so a running transfer keeps its port and address
                    if (ready_reg) begin
                        port_next = avs_writedata[11:10];
                        raddr_next = avs_writedata[7:0];
                        dir_next = avs_writedata[`TWSM_CMD_DIR_BIT];
                        go_next = avs_writedata[`TWSM_CMD_START_BIT];
                    end
                end
                `TWSM_OFF_DATA: wdata_next = avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    // Byte sequence: 0 dev addr write, 1 reg addr, 2 data or dev addr read, 3 read byte
    always_comb begin
        st_next = st_reg;
        ph_next = ph_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        sh_next = sh_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        ready_next = ready_reg;
        rdata_next = rdata_reg;
        nack_next = nack_reg;
        case (st_reg)
            TWSM_IDLE: begin
                scl_next = 1'b1;
                sda_next = 1'b1;
                if (go_reg) begin
                    ready_next = 1'b0;
                    st_next = TWSM_START;
                    ph_next = 2'h0;
                    byte_next = 2'h0;
                    nack_next = 1'b0;
                    sh_next = {ctrl_reg[15:9], 1'b0};
                end
            end
            TWSM_START, TWSM_RSTART: begin
                if (tk.tick) begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: begin
                            sda_next = 1'b1;
                            scl_next = 1'b1;
                        end
                        2'h1: sda_next = 1'b0;
                        2'h2: scl_next = 1'b0;
                        default: begin
                            st_next = TWSM_BITS;
                            bit_next = 4'h0;
                        end
                    endcase
                end
            end
            TWSM_BITS: begin
                if (tk.tick) begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: begin
                            if (bit_reg == 4'h8) begin
                                // Released for the slave's acknowledge, or the closing NACK
                                sda_next = 1'b1;
                            end else begin
                                sda_next = (byte_reg == 2'h3) ? 1'b1 : sh_reg[7];
                            end
                        end
                        2'h1: scl_next = 1'b1;
                        2'h2: begin
                            if (bit_reg == 4'h8) begin
                                if (byte_reg != 2'h3) begin
                                    nack_next = nack_reg | rx_bit;
                                end
                            end else begin
                                sh_next = {sh_reg[6:0], rx_bit};
                            end
                        end
                        default: begin
                            scl_next = 1'b0;
                            bit_next = bit_reg + 4'h1;
                            if (bit_reg == 4'h8) begin
                                byte_next = byte_reg + 2'h1;
                                case (byte_reg)
                                    2'h0: begin
                                        sh_next = raddr_reg;
                                        bit_next = 4'h0;
                                    end
                                    2'h1: begin
                                        if (dir_reg) begin
                                            st_next = TWSM_RSTART;
                                            sh_next = {ctrl_reg[15:9], 1'b1};
                                        end else begin
                                            sh_next = wdata_reg;
                                            bit_next = 4'h0;
                                        end
                                    end
                                    2'h2: begin
                                        if (dir_reg) begin
                                            bit_next = 4'h0;
                                        end else begin
                                            st_next = TWSM_STOP;
                                        end
                                    end
                                    default: begin
                                        rdata_next = sh_reg;
                                        st_next = TWSM_STOP;
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            end
            TWSM_STOP: begin
                if (tk.tick) begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_next = 1'b0;
                        2'h1: scl_next = 1'b1;
                        2'h2: sda_next = 1'b1;
                        default: st_next = TWSM_DONE;
                    endcase
                end
            end
            TWSM_DONE: begin
                ready_next = 1'b1;
                st_next = TWSM_IDLE;
            end
            default: st_next = TWSM_IDLE;
        endcase
    end
    // Open-drain drive: a line is enabled only while pulled low, and only if its pin is on
    always_comb begin
        scl_oe_next = 2'b00;
        for (int i = 0; i < 2; i++) begin
            scl_oe_next[i] = ctrl_reg[i] && (port_reg == 2'(i)) && !scl_next;
        end
        sda_oe_next = (ctrl_reg[2] || ctrl_reg[3]) && !sda_next;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `TWSM_CTRL_RST;
            raddr_reg <= 8'h00;
            port_reg <= 2'h0;
            dir_reg <= 1'b0;
            wdata_reg <= 8'h00;
            go_reg <= 1'b0;
            ack_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
            st_reg <= TWSM_IDLE;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            byte_reg <= 2'h0;
            sh_reg <= 8'h00;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            ready_reg <= 1'b1;
            rdata_reg <= 8'h00;
            nack_reg <= 1'b0;
            scl_oe_reg <= 2'b00;
            sda_oe_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            raddr_reg <= raddr_next;
            port_reg <= port_next;
            dir_reg <= dir_next;
            wdata_reg <= wdata_next;
            go_reg <= go_next;
            ack_reg <= ack_next;
            rd_reg <= rd_next;
            st_reg <= st_next;
            ph_reg <= ph_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            sh_reg <= sh_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            ready_reg <= ready_next;
            rdata_reg <= rdata_next;
            nack_reg <= nack_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end
    assign avs_readdata = rd_reg;
    assign avs_waitrequest = !ack_reg;
    assign scl_o = 2'b00;
    assign scl_oe = scl_oe_reg;
    assign shared_serial_data_pin_o = 1'b0;
    assign shared_serial_data_pin_oe = sda_oe_reg;
endmodule : twsm_master
`default_nettype wire

// File: design/twsm_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial mux master
`ifndef TWSM_REGS_SVH
`define TWSM_REGS_SVH
`define TWSM_OFF_CTRL 4'h0
`define TWSM_OFF_CMD 4'h4
`define TWSM_OFF_DATA 4'h8
`define TWSM_CTRL_RST 16'hA012
`define TWSM_SLV_ADDR_RST 7'h50
`define TWSM_FREQ_RST 2'h1
`define TWSM_CMD_READY_BIT 15
`define TWSM_CMD_START_BIT 9
`define TWSM_CMD_DIR_BIT 8
`define TWSM_CLK_HZ 125000000
`define TWSM_F50K_HZ 50000
`define TWSM_F100K_HZ 100000
`define TWSM_F400K_HZ 400000
`define TWSM_F2M_HZ 2000000
`define TWSM_Q50K (`TWSM_CLK_HZ / (4 * `TWSM_F50K_HZ))
`define TWSM_Q100K (`TWSM_CLK_HZ / (4 * `TWSM_F100K_HZ))
`define TWSM_Q400K (`TWSM_CLK_HZ / (4 * `TWSM_F400K_HZ))
`define TWSM_Q2M (`TWSM_CLK_HZ / (4 * `TWSM_F2M_HZ))
`endif

// File: design/twsm_pkg.sv
// Types shared by the serial mux master
package twsm_pkg;
    typedef enum logic [5:0] {
        TWSM_IDLE = 6'b000001,
        TWSM_START = 6'b000010,
        TWSM_BITS = 6'b000100,
        TWSM_RSTART = 6'b001000,
        TWSM_STOP = 6'b010000,
        TWSM_DONE = 6'b100000
    } twsm_state_t;
endpackage : twsm_pkg

// File: design/twsm_tick_if.sv
// Quarter-bit tick carrier between divider and master
`timescale 1ns/10ps
`default_nettype none
interface twsm_tick_if;
    logic [1:0] freq;
    logic run;
    logic tick;
    modport src (input freq, input run, output tick);
    modport dst (output freq, output run, input tick);
endinterface : twsm_tick_if
`default_nettype wire

// File: design/twsm_divider.sv
// Quarter-bit enable divider for the serial clock rates
`timescale 1ns/10ps
`default_nettype none
`include "twsm_regs.svh"
module twsm_divider
    import twsm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    twsm_tick_if.src tk
);
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [9:0] limit;
    always_comb begin
        case (tk.freq)
            2'h0: limit = 10'(`TWSM_Q50K - 1);
            2'h1: limit = 10'(`TWSM_Q100K - 1);
            2'h2: limit = 10'(`TWSM_Q400K - 1);
            default: limit = 10'(`TWSM_Q2M - 1);
        endcase
        cnt_next = 10'h000;
        tick_next = 1'b0;
        if (tk.run) begin
            if (cnt_reg >= limit) begin
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 10'h000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign tk.tick = tick_reg;
endmodule : twsm_divider
`default_nettype wire

// File: sim/twsm_master_checker.sv
// Port-level assertions for the serial mux master
`timescale 1ns/10ps
`default_nettype none
module twsm_master_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] scl_o,
    input wire logic [1:0] scl_oe,
    input wire logic shared_serial_data_pin_o,
    input wire logic shared_serial_data_pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic cmd_rd;
    assign cmd_rd = !avs_waitrequest && avs_read && avs_address == 4'h4;
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
        else $error("waitrequest low without a request");
    upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    open_drain_a: assert property (scl_o == 2'h0 && !shared_serial_data_pin_o)
        else $error("pin driven high");
    one_clock_a: assert property (!(scl_oe[0] && scl_oe[1]))
        else $error("both clock lines pulled");
    busy_ready_a: assert property (cmd_rd && (|scl_oe || shared_serial_data_pin_oe) |->
        !avs_readdata[15]) else $error("ready set during transfer");
    start_zero_a: assert property (cmd_rd |-> !avs_readdata[9])
        else $error("start bit reads back set");
    unmapped_zero_a: assert property (!avs_waitrequest && avs_read &&
        !(avs_address inside {4'h0, 4'h4, 4'h8})
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule : twsm_master_checker
bind twsm_master twsm_master_checker u_twsm_master_checker (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_o(scl_o),
    .scl_oe(scl_oe), .shared_serial_data_pin_o(shared_serial_data_pin_o),
    .shared_serial_data_pin_oe(shared_serial_data_pin_oe));
`default_nettype wire

// File: sim/twsm_slave_model.sv
// Behavioural two-wire slave with a byte memory on its own clock line
`timescale 1ns/10ps
`default_nettype none
module twsm_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50,
    parameter logic [7:0] FILL = 8'h00
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe
);
    logic [7:0] mem [0:255];
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic rd_mode = 1'b0;
    logic rd_next = 1'b0;
    logic nak = 1'b0;
    int n = 0;
    int phase = 3;
    initial begin
        sda_oe = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = FILL ^ 8'(i);
    end
    // Own clock line, shared data line
    always @(negedge sda) if (scl === 1'b1) begin
        phase = 0;
        n = 0;
        rd_mode = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) phase = 3;
    always @(posedge scl) begin
        if (n < 8) begin
            sh = {sh[6:0], sda};
            n = n + 1;
        end else if (n == 9) nak = sda;
    end
    // Never holds the clock low, so no stretching is possible
    always @(negedge scl) begin
        if (phase == 3) sda_oe = 1'b0;
        else if (n == 8) begin
            n = 9;
            if (phase == 0) begin
                rd_next = sh[0];
                sda_oe = (sh[7:1] == DEV_ADDR);
                phase = sda_oe ? 1 : 3;
            end else if (rd_mode) sda_oe = 1'b0;
            else begin
                sda_oe = 1'b1;
                if (phase == 1) ptr = sh;
                else mem[ptr] = sh;
                phase = 2;
            end
        end else if (n == 9) begin
            n = 0;
            // A NACK after a read byte ends the slave's part of the transfer
            if (rd_mode && nak) phase = 3;
            rd_mode = rd_next;
            sda_oe = (phase != 3) && rd_mode && !mem[ptr][7];
        end else if (rd_mode) sda_oe = !mem[ptr][7 - n];
    end
endmodule : twsm_slave_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the serial mux master
`timescale 1ns/10ps
`default_nettype none
`include "twsm_regs.svh"
module testbench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [1:0] scl_o;
    logic [1:0] scl_oe;
    logic sda_o;
    logic sda_oe;
    logic s0_oe;
    logic s1_oe;
    logic [1:0] scl;
    logic sda;
    logic [31:0] r;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #4 mclk = ~mclk;
    // Pull-ups on all three lines
    assign scl = ~scl_oe;
    assign sda = ~(sda_oe | s0_oe | s1_oe);
    twsm_master u_twsm_master (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .scl_o(scl_o), .scl_oe(scl_oe), .scl_i(scl), .shared_serial_data_pin_o(sda_o),
        .shared_serial_data_pin_oe(sda_oe), .shared_serial_data_pin_i(sda));
    twsm_slave_model #(.FILL(8'h40)) u_s0 (.scl(scl[0]), .sda(sda), .sda_oe(s0_oe));
    twsm_slave_model #(.FILL(8'h90)) u_s1 (.scl(scl[1]), .sda(sda), .sda_oe(s1_oe));
    task automatic complete_run;
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch at %0t: period %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng
    // Holds the request until waitrequest is seen low, then releases for one cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        adr <= a;
        wdat <= {16'h0000, d};
        wr_s <= w;
        rd_s <= !w;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        r = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
        bus(1'b0, a, 16'h0000);
        chk(r[15:0] & m, exp);
    endtask : rchk
    task automatic xfer(input logic [1:0] p, input logic dir, input logic [7:0] ra,
        input logic [7:0] d, input logic twice);
        rchk(`TWSM_OFF_CMD, 16'h8000, 16'h8000);
        if (!dir) bus(1'b1, `TWSM_OFF_DATA, {8'h00, d});
        bus(1'b1, `TWSM_OFF_CMD, {4'h0, p, 1'b1, dir, ra});
        repeat (8) @(posedge mclk);
        // A start while busy must be ignored
        if (twice) bus(1'b1, `TWSM_OFF_CMD, {4'h0, p, 2'b10, ra + 8'h01});
        rchk(`TWSM_OFF_CMD, 16'h0000, 16'h8000);
        for (int i = 0; i < 30000 && r[15] !== 1'b1; i++) bus(1'b0, `TWSM_OFF_CMD, 16'h0000);
        chk(r[15:0] & 16'h8000, 16'h8000);
    endtask : xfer
    task automatic period(input int q);
        int t0;
        repeat (3) @(negedge scl[0]);
        t0 = cyc;
        @(negedge scl[0]);
        chk_rng(cyc - t0, 4 * q, 4 * q + 8);
    endtask : period
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rchk(`TWSM_OFF_CTRL, `TWSM_CTRL_RST, 16'hFFFF);
        rchk(`TWSM_OFF_CMD, 16'h8000, 16'h8200);
        bus(1'b1, 4'hC, 16'hFFFF);
        rchk(4'hC, 16'h0000, 16'hFFFF);
        rchk(`TWSM_OFF_CTRL, `TWSM_CTRL_RST, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TWSM_OFF_CTRL, 16'hA00F | 16'(i << 4));
            rchk(`TWSM_OFF_CTRL, 16'hA00F | 16'(i << 4), 16'hFFFF);
        end
        fork
            xfer(2'h0, 1'b0, 8'h05, 8'hA5, 1'b0);
            period(`TWSM_Q2M);
        join
        chk({8'h00, u_s0.mem[5]}, 16'h00A5);
        chk({8'h00, u_s1.mem[5]}, 16'h0095);
        xfer(2'h1, 1'b0, 8'h06, 8'h3C, 1'b1);
        chk({u_s1.mem[6], u_s1.mem[7]}, 16'h3C97);
        chk({8'h00, u_s0.mem[6]}, 16'h0046);
        xfer(2'h0, 1'b1, 8'h05, 8'h00, 1'b0);
        rchk(`TWSM_OFF_DATA, 16'hA53C, 16'hFFFF);
        xfer(2'h1, 1'b1, 8'h10, 8'h00, 1'b0);
        rchk(`TWSM_OFF_DATA, 16'h803C, 16'hFFFF);
        repeat (300) @(posedge mclk);
        rchk(`TWSM_OFF_CMD, 16'h8000, 16'h8200);
        bus(1'b1, `TWSM_OFF_CTRL, 16'hA02F);
        fork
            xfer(2'h0, 1'b0, 8'h20, 8'h5A, 1'b0);
            period(`TWSM_Q400K);
        join
        chk({8'h00, u_s0.mem[8'h20]}, 16'h005A);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
